// ===== src/etr_defines.svh
// Constants for the elapsed time recorder core.
// Assumes a 100 MHz core clock and APB register access.
`ifndef ETR_DEFINES_SVH
`define ETR_DEFINES_SVH
`define ETR_OFF_CONFIG 8'h00
`define ETR_OFF_TRIP 8'h04
`define ETR_OFF_TOTAL 8'h08
`define ETR_OFF_EVENTS 8'h0C
`define ETR_OFF_ELAPSED 8'h10
`define ETR_OFF_USER0 8'h14
`define ETR_OFF_USER1 8'h18
`define ETR_OFF_USER2 8'h1C
`define ETR_OFF_STATUS 8'h20
`define ETR_OFF_CLEAR 8'h24
`define ETR_OFF_CFG_LOCK 8'h28
`define ETR_OFF_MEM_LOCK 8'h2C
`define ETR_CMD_CLEAR 32'h0000_0055
`define ETR_CMD_CFG_LOCK 32'h0000_00AA
`define ETR_CMD_MEM_LOCK 32'h0000_00F0
`define ETR_CFG_SEL 7
`define ETR_CFG_PULSE 3
`define ETR_CFG_CLR_EN 2
`define ETR_CFG_POL 1
`define ETR_CFG_RST 8'h00
`define ETR_CLK_HZ 100000000
`define ETR_QTR_MS 250
`define ETR_QTR_CYC (`ETR_CLK_HZ / 1000 * `ETR_QTR_MS)
`define ETR_BUSY_MS 200
`define ETR_BUSY_CYC (`ETR_CLK_HZ / 1000 * `ETR_BUSY_MS)
`define ETR_GLITCH_CYC 16
`define ETR_PULSE_CYC 8'h0A
`define ETR_PULSE_CNT 4
`endif

// ===== src/etr_pkg.sv
// Types shared by the elapsed time recorder modules.
// Assumes nothing beyond the defines header.
`default_nettype none
package etr_pkg;
  typedef enum logic [1:0] {
    ETR_IDLE = 2'b00,
    ETR_LOW = 2'b01,
    ETR_HIGH = 2'b10
  } etr_pulse_st_t;
endpackage : etr_pkg
`default_nettype wire

// ===== src/etr_limit_if.sv
// Interface between the core and the limit pin driver.
// Assumes both ends run on core_clk.
`default_nettype none
interface etr_limit_if;
  logic alarm;
  logic pulse_mode;
  logic polarity;
  logic pin_mode;
  logic pin_high;
  logic pin_out;
  modport core (output alarm, output pulse_mode, output polarity,
    output pin_mode, input pin_high, input pin_out);
  modport drv (input alarm, input pulse_mode, input polarity,
    input pin_mode, output pin_high, output pin_out);
endinterface : etr_limit_if
`default_nettype wire

// ===== src/etr_limit_drv.sv
// Limit pin driver: level or four-pulse alarm style.
// Assumes a synchronised pin level input.
`default_nettype none
`include "etr_defines.svh"
module etr_limit_drv
  import etr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Synchronised pin level
  input wire logic pin_sync,
  // Core side
  etr_limit_if.drv lim
);
  etr_pulse_st_t st, next_st;
  logic [7:0] tmr, next_tmr;
  logic [2:0] cnt, next_cnt;
  logic act_d, next_act_d;
  logic pin_d, next_pin_d;
  logic boot, next_boot;
  logic pout, next_pout;
  logic active;
  assign active = lim.alarm ^ lim.polarity;
  assign lim.pin_high = pin_sync;
  assign lim.pin_out = pout;

  always_comb begin
    next_st = st;
    next_tmr = tmr;
    next_cnt = cnt;
    next_act_d = active;
    next_pin_d = pin_sync;
    next_boot = 1'b0;
    next_pout = 1'b1;
    if (lim.pin_mode) begin
      next_st = ETR_IDLE;
    end else if (!lim.pulse_mode) begin
      next_st = ETR_IDLE;
      next_pout = !active;
    end else begin
      unique case (st)
        ETR_IDLE: begin
          // Start on power-up, alarm rise or external pull and release
          if (active && (boot || !act_d || (pin_sync && !pin_d))) begin
            next_st = ETR_LOW;
            next_tmr = `ETR_PULSE_CYC;
            next_cnt = 3'(`ETR_PULSE_CNT);
          end
        end
        ETR_LOW: begin
          next_tmr = tmr - 8'h01;
          if (tmr == 8'h01) begin
            next_st = ETR_HIGH;
            next_tmr = `ETR_PULSE_CYC;
            next_cnt = cnt - 3'h1;
          end
        end
        ETR_HIGH: begin
          next_tmr = tmr - 8'h01;
          if (tmr == 8'h01) begin
            next_st = (cnt == 3'h0) ? ETR_IDLE : ETR_LOW;
            next_tmr = `ETR_PULSE_CYC;
          end
        end
        default: next_st = ETR_IDLE;
      endcase
      if (next_st == ETR_LOW) next_pout = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= ETR_IDLE;
      tmr <= 8'h00;
      cnt <= 3'h0;
      act_d <= 1'b0;
      pin_d <= 1'b1;
      boot <= 1'b1;
      pout <= 1'b1;
    end else begin
      st <= next_st;
      tmr <= next_tmr;
      cnt <= next_cnt;
      act_d <= next_act_d;
      pin_d <= next_pin_d;
      boot <= next_boot;
      pout <= next_pout;
    end
  end

  AST_LEVEL_LOW: assert property (@(posedge core_clk) disable iff (rst)
    (!lim.pin_mode && !lim.pulse_mode && active) |=> !pout)
    else $error("Level style limit not low while alarm active");
  AST_PULSE_FOUR: assert property (@(posedge core_clk)
    disable iff (rst)
    (st == ETR_IDLE && next_st == ETR_LOW) |=> (cnt == 3'h4 && !pout))
    else $error("Pulse burst did not start with four pulses");
endmodule : etr_limit_drv
`default_nettype wire

// ===== src/etr_core.sv
// Elapsed time recorder core with APB registers.
// Assumes event and limit pins are asynchronous to core_clk.
//
// Behaviour
// - Event start loads total into elapsed counter
// - Count quarter seconds while event active
// - Event end bumps events, stores total
// - Alarm only with nonzero trip, select zero
// - Limit asserts at or above trip, polarity
// - Pulse style drives four low pulses
// - Level style holds limit low while alarm
// - Clear needs enable or select with pin high
// - Two lock commands lock config and trip
// - Locked config still clears counters when enabled
// - Two memory commands set permanent memory lock
// - Memory lock refuses user byte writes
// - Unlocked config: config, trip and unlocked user memory writable
// - Both locks leave only clear, event, pin
// - Glitch filter on event input
// - Bus refused 200 ms after event change
// - Select one makes limit pin clear enable
//
// Our own choices: the address map and the APB register port.
`default_nettype none
`include "etr_defines.svh"
module etr_core
  import etr_pkg::*;
#(
  parameter int QTR_CYC = `ETR_QTR_CYC,
  parameter int BUSY_CYC = `ETR_BUSY_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic event_pin,
  input wire logic limit_pin_in,
  output logic limit_pin_out,
  output logic limit_pin_oe_n
);
  // Synchronisers
  logic ev_s1, ev_s2, pin_s1, pin_s2;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ev_s1 <= 1'b0;
      ev_s2 <= 1'b0;
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
    end else begin
      ev_s1 <= event_pin;
      ev_s2 <= ev_s1;
      pin_s1 <= limit_pin_in;
      pin_s2 <= pin_s1;
    end
  end

  // State
  logic [7:0] config_reg, next_config_reg;
  logic [31:0] trip, next_trip;
  logic [31:0] total, next_total;
  logic [16:0] events, next_events;
  logic [31:0] elapsed_counter, next_elapsed_counter;
  logic [7:0] user_mem [0:9];
  logic [7:0] next_user_mem [0:9];
  logic config_lock_flag, next_config_lock_flag;
  logic mem_lock, next_mem_lock;
  logic cfg_arm, next_cfg_arm;
  logic mem_arm, next_mem_arm;
  logic [4:0] filt_cnt, next_filt_cnt;
  logic ev_f, next_ev_f;
  logic [31:0] qtr_cnt, next_qtr_cnt;
  logic qtr_tick, next_qtr_tick;
  logic [31:0] busy_cnt, next_busy_cnt;
  logic alarm, next_alarm;
  logic [31:0] prdata_r, next_prdata_r;
  logic pready_r, next_pready_r;
  logic pslverr_r, next_pslverr_r;

  logic limit_or_clear_select, pulse_style_select, clr_en, polarity;
  assign limit_or_clear_select = config_reg[`ETR_CFG_SEL];
  assign pulse_style_select = config_reg[`ETR_CFG_PULSE];
  assign clr_en = config_reg[`ETR_CFG_CLR_EN];
  assign polarity = config_reg[`ETR_CFG_POL];

  etr_limit_if lim();
  assign lim.alarm = alarm;
  assign lim.pulse_mode = pulse_style_select;
  assign lim.polarity = polarity;
  assign lim.pin_mode = limit_or_clear_select;

  etr_limit_drv u_drv (
    .core_clk(core_clk),
    .rst(rst),
    .pin_sync(pin_s2),
    .lim(lim)
  );

  logic acc, wr, busy;
  // Filter takes a new event level this cycle
  logic ev_take;
  assign ev_take = ev_s2 != ev_f && filt_cnt == 5'(`ETR_GLITCH_CYC);
  logic [3:0] ui;
  assign busy = busy_cnt != 32'h0000_0000;
  assign acc = psel && penable && !pready_r;
  assign wr = acc && pwrite && !busy;
  assign ui = 4'(paddr - `ETR_OFF_USER0);

  always_comb begin
    next_config_reg = config_reg;
    next_trip = trip;
    next_total = total;
    next_events = events;
    next_elapsed_counter = elapsed_counter;
    for (int i = 0; i < 10; i++) next_user_mem[i] = user_mem[i];
    next_config_lock_flag = config_lock_flag;
    next_mem_lock = mem_lock;
    next_cfg_arm = cfg_arm;
    next_mem_arm = mem_arm;
    next_filt_cnt = filt_cnt;
    next_ev_f = ev_f;
    next_qtr_tick = 1'b0;
    next_qtr_cnt = qtr_cnt;
    next_busy_cnt = busy ? busy_cnt - 32'h0000_0001 : busy_cnt;
    next_prdata_r = 32'h0000_0000;
    next_pready_r = acc;
    next_pslverr_r = acc && busy;
    // Glitch filter: level must hold before it is accepted
    if (ev_s2 == ev_f) begin
      next_filt_cnt = 5'h00;
    end else if (filt_cnt == 5'(`ETR_GLITCH_CYC)) begin
      next_ev_f = ev_s2;
      next_filt_cnt = 5'h00;
      next_busy_cnt = 32'(BUSY_CYC);
      if (ev_s2) begin
        next_elapsed_counter = total;
      end else begin
        next_total = elapsed_counter;
        next_events = events + 17'h0_0001;
      end
    end else begin
      next_filt_cnt = filt_cnt + 5'h01;
    end
    // Quarter second prescaler, runs only during an event
    if (!ev_f) begin
      next_qtr_cnt = 32'h0000_0000;
    end else if (qtr_cnt == 32'(QTR_CYC - 1)) begin
      next_qtr_cnt = 32'h0000_0000;
      next_qtr_tick = 1'b1;
    end else begin
      next_qtr_cnt = qtr_cnt + 32'h0000_0001;
    end
    if (qtr_tick && ev_f) begin
      next_elapsed_counter = elapsed_counter + 32'h0000_0001;
    end
    next_alarm = trip != 32'h0000_0000 && !limit_or_clear_select
      && elapsed_counter >= trip;
    if (wr) begin
      unique case (paddr)
        `ETR_OFF_CONFIG: if (!config_lock_flag) begin
          next_config_reg = pwdata[7:0];
        end
        `ETR_OFF_TRIP: if (!config_lock_flag) next_trip = pwdata;
        `ETR_OFF_CLEAR: begin
          // An event edge taken this cycle loads or stores, clear is dropped
          if (pwdata == `ETR_CMD_CLEAR && !ev_take && (clr_en ||
              (limit_or_clear_select && pin_s2))) begin
            next_total = 32'h0000_0000;
            next_elapsed_counter = 32'h0000_0000;
            next_events = 17'h0_0000;
          end
        end
        `ETR_OFF_CFG_LOCK: if (pwdata == `ETR_CMD_CFG_LOCK) begin
          next_cfg_arm = 1'b1;
          if (cfg_arm) next_config_lock_flag = 1'b1;
        end
        `ETR_OFF_MEM_LOCK: if (pwdata == `ETR_CMD_MEM_LOCK) begin
          next_mem_arm = 1'b1;
          if (mem_arm) next_mem_lock = 1'b1;
        end
        `ETR_OFF_USER0, `ETR_OFF_USER1, `ETR_OFF_USER2: begin
          for (int b = 0; b < 4; b++) begin
            if (!mem_lock && int'(ui) + b < 10) begin
              next_user_mem[int'(ui) + b] = pwdata[8*b +: 8];
            end
          end
        end
        default: ;
      endcase
    end
    if (acc && !pwrite && !busy) begin
      unique case (paddr)
        `ETR_OFF_CONFIG: next_prdata_r = {24'h00_0000, config_reg[7:6],
          config_lock_flag, mem_lock, config_reg[3:0]};
        `ETR_OFF_TRIP: next_prdata_r = trip;
        `ETR_OFF_TOTAL: next_prdata_r = total;
        `ETR_OFF_EVENTS: next_prdata_r = {15'h0000, events};
        `ETR_OFF_ELAPSED: next_prdata_r = elapsed_counter;
        `ETR_OFF_USER0, `ETR_OFF_USER1, `ETR_OFF_USER2: begin
          for (int b = 0; b < 4; b++) begin
            if (int'(ui) + b < 10) begin
              next_prdata_r[8*b +: 8] = user_mem[int'(ui) + b];
            end
          end
        end
        `ETR_OFF_STATUS: next_prdata_r = {27'h000_0000, busy, ev_f,
          lim.pin_high, lim.pin_out, alarm};
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      config_reg <= `ETR_CFG_RST;
      trip <= 32'h0000_0000;
      total <= 32'h0000_0000;
      events <= 17'h0_0000;
      elapsed_counter <= 32'h0000_0000;
      for (int i = 0; i < 10; i++) user_mem[i] <= 8'h00;
      config_lock_flag <= 1'b0;
      mem_lock <= 1'b0;
      cfg_arm <= 1'b0;
      mem_arm <= 1'b0;
      filt_cnt <= 5'h00;
      ev_f <= 1'b0;
      qtr_cnt <= 32'h0000_0000;
      qtr_tick <= 1'b0;
      busy_cnt <= 32'h0000_0000;
      alarm <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      config_reg <= next_config_reg;
      trip <= next_trip;
      total <= next_total;
      events <= next_events;
      elapsed_counter <= next_elapsed_counter;
      for (int i = 0; i < 10; i++) user_mem[i] <= next_user_mem[i];
      config_lock_flag <= next_config_lock_flag;
      mem_lock <= next_mem_lock;
      cfg_arm <= next_cfg_arm;
      mem_arm <= next_mem_arm;
      filt_cnt <= next_filt_cnt;
      ev_f <= next_ev_f;
      qtr_cnt <= next_qtr_cnt;
      qtr_tick <= next_qtr_tick;
      busy_cnt <= next_busy_cnt;
      alarm <= next_alarm;
      prdata_r <= next_prdata_r;
      pready_r <= next_pready_r;
      pslverr_r <= next_pslverr_r;
    end
  end

  // Outputs from flops, limit_pin_out tied low; pin driven only while low is wanted
  logic oe_n_r, next_oe_n_r;
  always_comb begin
    next_oe_n_r = limit_or_clear_select || lim.pin_out;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      oe_n_r <= 1'b1;
    end else begin
      oe_n_r <= next_oe_n_r;
    end
  end
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign limit_pin_out = 1'b0;
  assign limit_pin_oe_n = oe_n_r;

  AST_LOAD: assert property (@(posedge core_clk) disable iff (rst)
    (!ev_f && next_ev_f) |=> elapsed_counter == $past(total))
    else $error("Elapsed counter not loaded at event start");
  AST_STORE: assert property (@(posedge core_clk) disable iff (rst)
    (ev_f && !next_ev_f) |=>
      (total == $past(elapsed_counter) && events == $past(events) + 17'h1))
    else $error("Event end did not store total");
  AST_COUNT: assert property (@(posedge core_clk) disable iff (rst)
    (qtr_tick && ev_f && next_ev_f && !wr) |=>
      elapsed_counter == $past(elapsed_counter) + 32'h1)
    else $error("Elapsed counter missed a tick");
  AST_ALARM_EN: assert property (@(posedge core_clk) disable iff (rst)
    (trip == 32'h0 || limit_or_clear_select) |=> !alarm)
    else $error("Alarm without trip or with select set");
  AST_CFG_LOCK: assert property (@(posedge core_clk) disable iff (rst)
    config_lock_flag |=> $stable(trip) && $stable(config_reg))
    else $error("Locked configuration changed");
  AST_MEM_STICKY: assert property (@(posedge core_clk)
    disable iff (rst) mem_lock |=> mem_lock)
    else $error("Memory lock cleared");
  AST_BUSY: assert property (@(posedge core_clk) disable iff (rst)
    (ev_f != $past(ev_f)) |-> busy)
    else $error("Bus not refused after event change");
  AST_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
    (wr && paddr == `ETR_OFF_CLEAR && !clr_en && !limit_or_clear_select
      && !(ev_f && !next_ev_f)) |=> total == $past(total))
    else $error("Clear accepted while disabled");
  // Bus refusal, tick, clear, lock and pin checks
  AST_REFUSE: assert property (@(posedge core_clk) disable iff (rst)
    (acc && busy) |=> (pslverr_r && prdata_r == 32'h0000_0000))
    else $error("Busy bus access not refused");
  AST_TICK_ONE: assert property (@(posedge core_clk) disable iff (rst)
    qtr_tick |=> !qtr_tick)
    else $error("Quarter second tick longer than one cycle");
  AST_CLR_DONE: assert property (@(posedge core_clk) disable iff (rst)
    (wr && paddr == `ETR_OFF_CLEAR && pwdata == `ETR_CMD_CLEAR && clr_en
      && !ev_take) |=> (total == 32'h0000_0000 && events == 17'h0_0000))
    else $error("Enabled clear did not zero the counters");
  AST_CFG_SET: assert property (@(posedge core_clk) disable iff (rst)
    (wr && paddr == `ETR_OFF_CFG_LOCK && pwdata == `ETR_CMD_CFG_LOCK
      && cfg_arm) |=> config_lock_flag)
    else $error("Second lock command did not lock configuration");
  AST_CFG_ONCE: assert property (@(posedge core_clk) disable iff (rst)
    !cfg_arm |=> !config_lock_flag)
    else $error("Configuration locked by a single command");
  AST_MEM_SET: assert property (@(posedge core_clk) disable iff (rst)
    (wr && paddr == `ETR_OFF_MEM_LOCK && pwdata == `ETR_CMD_MEM_LOCK
      && mem_arm) |=> mem_lock)
    else $error("Second memory command did not lock memory");
  AST_MEM_ONCE: assert property (@(posedge core_clk) disable iff (rst)
    !mem_arm |=> !mem_lock)
    else $error("Memory locked by a single command");
  AST_USER_RO: assert property (@(posedge core_clk) disable iff (rst)
    mem_lock |=> (user_mem[0] == $past(user_mem[0])
      && user_mem[8] == $past(user_mem[8])
      && user_mem[9] == $past(user_mem[9])))
    else $error("Locked user memory changed");
  AST_PIN_SEL: assert property (@(posedge core_clk) disable iff (rst)
    limit_or_clear_select |=> oe_n_r)
    else $error("Limit pin driven while used as clear enable");
endmodule : etr_core
`default_nettype wire

// ===== dv/etr_pin_partner.sv
// Far side of the limit pin: pull-up plus an outside switch to ground.
// Assumes open-drain data is driven only while the enable is low.
`default_nettype none
module etr_pin_partner (
  // Device side
  input wire logic limit_pin_out,
  input wire logic limit_pin_oe_n,
  // Outside switch
  input wire logic pull_low,
  // Resolved level
  output logic limit_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pulled high unless either party grounds it
  assign limit_pin_in = ~pull_low & (limit_pin_oe_n | limit_pin_out);
endmodule : etr_pin_partner
`default_nettype wire

// ===== dv/elapsed_time_recorder_tb.sv
// Self-checking bench for the elapsed time recorder core.
// Assumes the pin partner model and shortened tick and busy counts.
`default_nettype none
`include "etr_defines.svh"
module elapsed_time_recorder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic event_pin = 1'b0;
  logic pull_low = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic limit_pin_in;
  logic limit_pin_out;
  logic limit_pin_oe_n;
  logic prev_oe_n = 1'b1;
  logic [31:0] rd;
  logic [31:0] t0;
  logic er;
  int nf = 0;
  int err_count = 0;
  int checked = 0;
  always #5 core_clk = ~core_clk;
  etr_core #(.QTR_CYC(20), .BUSY_CYC(50)) i_etr_core (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_pin(event_pin),
    .limit_pin_in(limit_pin_in), .limit_pin_out(limit_pin_out),
    .limit_pin_oe_n(limit_pin_oe_n));
  etr_pin_partner i_etr_pin_partner (
    .limit_pin_out(limit_pin_out), .limit_pin_oe_n(limit_pin_oe_n),
    .pull_low(pull_low), .limit_pin_in(limit_pin_in));
  // Counts device pulls on the limit pin
  always @(posedge core_clk) begin
    prev_oe_n <= limit_pin_oe_n;
    if (prev_oe_n === 1'b1 && limit_pin_oe_n === 1'b0) begin
      nf <= nf + 1;
    end
  end
  task automatic wrap_up;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    // Pause four cycles after each write
    cyc(4);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask : rdc
  task automatic t_event(input int n);
    @(posedge core_clk);
    event_pin <= 1'b1;
    cyc(30);
    apb(1'b0, `ETR_OFF_STATUS, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    cyc(n);
    event_pin <= 1'b0;
    cyc(100);
  endtask : t_event
  task automatic t_count;
    rdc(`ETR_OFF_EVENTS, 32'h0000_0000);
    t_event(170);
    apb(1'b0, `ETR_OFF_TOTAL, 32'h0000_0000);
    t0 = rd;
    chk({31'h0, t0 >= 9 && t0 <= 11}, 32'h0000_0001);
    rdc(`ETR_OFF_EVENTS, 32'h0000_0001);
    rdc(`ETR_OFF_ELAPSED, t0);
    t_event(170);
    apb(1'b0, `ETR_OFF_TOTAL, 32'h0000_0000);
    chk({31'h0, rd - t0 >= 9 && rd - t0 <= 11}, 32'h0000_0001);
    rdc(`ETR_OFF_EVENTS, 32'h0000_0002);
  endtask : t_count
  task automatic t_glitch;
    // Spikes of 80 ns, every 170 ns
    repeat (3) begin
      @(posedge core_clk);
      event_pin <= 1'b1;
      cyc(8);
      event_pin <= 1'b0;
      cyc(8);
    end
    cyc(20);
    rdc(`ETR_OFF_EVENTS, 32'h0000_0002);
  endtask : t_glitch
  task automatic t_level;
    logic [7:0] a[8];
    logic [31:0] d[8];
    logic e[8];
    a = '{`ETR_OFF_CONFIG, `ETR_OFF_TRIP, `ETR_OFF_CONFIG, `ETR_OFF_TRIP,
          `ETR_OFF_CONFIG, `ETR_OFF_TRIP, `ETR_OFF_TRIP, `ETR_OFF_CONFIG};
    d = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0002, 32'hFFFF_FFFF,
          32'h0000_0000, 32'h0000_0000, 32'h0000_0001, 32'h0000_0080};
    e = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 8; i++) begin
      wr(a[i], d[i]);
      cyc(5);
      chk({31'h0, limit_pin_oe_n}, {31'h0, e[i]});
    end
    rdc(`ETR_OFF_TRIP, 32'h0000_0001);
    rdc(`ETR_OFF_STATUS, 32'h0000_0006);
  endtask : t_level
  task automatic t_pulse;
    int k;
    wr(`ETR_OFF_TRIP, 32'h0000_0000);
    wr(`ETR_OFF_CONFIG, 32'h0000_0008);
    k = nf;
    wr(`ETR_OFF_TRIP, 32'h0000_0001);
    cyc(300);
    chk(nf - k, 32'h0000_0004);
    k = nf;
    pull_low <= 1'b1;
    cyc(5);
    pull_low <= 1'b0;
    cyc(300);
    chk(nf - k, 32'h0000_0004);
    wr(`ETR_OFF_TRIP, 32'h0000_0000);
  endtask : t_pulse
  task automatic t_clear;
    apb(1'b0, `ETR_OFF_TOTAL, 32'h0000_0000);
    t0 = rd;
    wr(`ETR_OFF_CONFIG, 32'h0000_0000);
    wr(`ETR_OFF_CLEAR, `ETR_CMD_CLEAR);
    rdc(`ETR_OFF_TOTAL, t0);
    wr(`ETR_OFF_CONFIG, 32'h0000_0080);
    pull_low <= 1'b1;
    cyc(5);
    wr(`ETR_OFF_CLEAR, `ETR_CMD_CLEAR);
    rdc(`ETR_OFF_TOTAL, t0);
    pull_low <= 1'b0;
    cyc(5);
    wr(`ETR_OFF_CLEAR, `ETR_CMD_CLEAR);
    rdc(`ETR_OFF_TOTAL, 32'h0000_0000);
    rdc(`ETR_OFF_EVENTS, 32'h0000_0000);
  endtask : t_clear
  task automatic t_lock;
    wr(`ETR_OFF_CONFIG, 32'h0000_0004);
    wr(`ETR_OFF_CFG_LOCK, `ETR_CMD_CFG_LOCK);
    rdc(`ETR_OFF_CONFIG, 32'h0000_0004);
    wr(`ETR_OFF_CFG_LOCK, `ETR_CMD_CFG_LOCK);
    wr(`ETR_OFF_CONFIG, 32'h0000_0000);
    wr(`ETR_OFF_TRIP, 32'h0000_0005);
    rdc(`ETR_OFF_CONFIG, 32'h0000_0024);
    rdc(`ETR_OFF_TRIP, 32'h0000_0000);
    wr(`ETR_OFF_USER2, 32'hFFFF_FFFF);
    rdc(`ETR_OFF_USER2, 32'h0000_FFFF);
    wr(`ETR_OFF_MEM_LOCK, `ETR_CMD_MEM_LOCK);
    wr(`ETR_OFF_MEM_LOCK, `ETR_CMD_MEM_LOCK);
    rdc(`ETR_OFF_CONFIG, 32'h0000_0034);
    wr(`ETR_OFF_USER2, 32'h0000_0000);
    rdc(`ETR_OFF_USER2, 32'h0000_FFFF);
    wr(`ETR_OFF_CLEAR, `ETR_CMD_CLEAR);
    rdc(`ETR_OFF_TOTAL, 32'h0000_0000);
    rdc(`ETR_OFF_EVENTS, 32'h0000_0000);
  endtask : t_lock
  initial begin
    cyc(10);
    rst <= 1'b0;
    rdc(`ETR_OFF_CONFIG, 32'(`ETR_CFG_RST));
    rdc(8'h30, 32'h0000_0000);
    t_count;
    t_glitch;
    t_level;
    t_pulse;
    t_clear;
    t_event(170);
    t_lock;
    wrap_up;
  end
  initial begin
    #200000;
    err_count++;
    $display("ERROR %0t watchdog expired", $time);
    wrap_up;
  end
endmodule : elapsed_time_recorder_tb
`default_nettype wire
